// [design/tdi_pkg.sv]
// Shared constants and types for the line-trigger camera control link.
// Assumes a single 25 MHz system clock on both ends.
package tdi_pkg;
	localparam int CLK_HZ = 25000000;
	// Master line rate, 23.191 kHz, in millihertz
	localparam longint MASTER_RATE_MHZ = 64'h000000000161DDD8;
	localparam int MASTER_PERIOD_CYC = int'((64'h00000000000003E8 * CLK_HZ) / MASTER_RATE_MHZ);
	// Minimum trigger rate 300 Hz; slower means trigger lost
	localparam int MIN_TRIG_HZ = 300;
	localparam int TRIG_TIMEOUT_CYC = CLK_HZ / MIN_TRIG_HZ;
	// Minimum trigger high time, 100 ns
	localparam int TRIG_HIGH_NS = 100;
	localparam int TRIG_HIGH_CYC = (TRIG_HIGH_NS * (CLK_HZ / 1000000) + 999) / 1000;
	// Valid pixels per line per channel
	localparam int LINE_PIXELS = 512;
	localparam int CHANNELS = 4;
	localparam int GAIN_W = 10;
	localparam int OFFS_W = 10;
	localparam logic [9:0] GAIN_RST = 10'h190;
	localparam logic [9:0] OFFS_RST = 10'h040;
	// Depth shown after reset, matching idle select pins
	localparam logic [6:0] DEPTH_RST = 7'h60;
	// Host register offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_GAIN0 = 4'h4;
	localparam logic [3:0] REG_OFFS0 = 4'h8;
	localparam logic [3:0] REG_LINES = 4'hC;
	// Control bit positions
	localparam int CTRL_TRIG_EN = 0;
	localparam int CTRL_FRAME = 1;
	localparam int CTRL_SEL_LO = 2;
	localparam int CTRL_SEL_HI = 3;
	localparam int CTRL_STORE = 4;
	localparam int CTRL_RATE_LSB = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000000C;
	typedef enum logic [1:0] {ST_MASTER, ST_SLAVE} op_mode_t;
	typedef enum logic [1:0] {LN_IDLE, LN_OUT} line_state_t;
endpackage

// [design/tdi_link_if.sv]
// Interface joining the trigger source and the camera control logic.
// Assumes both ends share sys_clk.
interface tdi_link_if;
	logic line_trigger_in;
	logic frame_select_n;
	logic depth_select_lo;
	logic depth_select_hi;
	logic line_valid_out;
	logic line_valid_second_out;
	logic frame_valid_out;
	logic [31:0] pixel_data;
	logic cal_we;
	logic cal_store;
	logic [2:0] cal_addr;
	logic [9:0] cal_data;
	modport camera (input line_trigger_in, frame_select_n, depth_select_lo, depth_select_hi,
		cal_we, cal_store, cal_addr, cal_data,
		output line_valid_out, line_valid_second_out, frame_valid_out, pixel_data);
	modport source (output line_trigger_in, frame_select_n, depth_select_lo, depth_select_hi,
		cal_we, cal_store, cal_addr, cal_data,
		input line_valid_out, line_valid_second_out, frame_valid_out, pixel_data);
endinterface

// [design/sync2.sv]
// Two-flop synchroniser for one level input.
// Assumes sys_clk domain on the output side.
module sync2 #(
	parameter bit RST_VAL = 1'b0 // Level held in reset, the pin's idle level
) (
	input wire logic sys_clk, // System clock
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic d, // Asynchronous level
	output logic q // Synchronised level
);
	logic s1_r;
	logic s1_nxt;
	logic q_nxt;
	always_comb begin
		s1_nxt = d;
		q_nxt = s1_r;
	end
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			s1_r <= RST_VAL;
			q <= RST_VAL;
		end else begin
			s1_r <= s1_nxt;
			q <= q_nxt;
		end
	end
endmodule

// [design/tdi_camera_ctrl.sv]
// Camera end: line trigger, master/slave timing, framing, depth, gain/offset.
// Assumes link inputs come from pins and are asynchronous to sys_clk.
// Functional notes
// - Trigger rising edge starts one line readout
// - In slave, no toggling trigger, no valid line data
// - Source keeps trigger at or above 300 Hz; the source here takes any 24-bit period, with no lower rate limit
// - Source holds trigger high 100 ns minimum
// - Framing only in master, fixed line rate
// - Source keeps trigger idle at power-up
// - Frame select low requests framing
// - Depth select decode 96/64/32/16, default 96
// - Small variant decodes 96/64/48/32
// - Working gain/offset writes apply immediately
// - Stored gain/offset apply after next reset
// - No trigger yet: master at 23.191 kHz
// - First trigger enters slave, tracks trigger
// - Slave kept until reset; fault on loss
// - Line valid high only with valid pixels
//
// The register addresses and the plain strobed port were left to the implementer.
module tdi_camera_ctrl #(
	parameter bit SMALL_ARRAY = 1'b0,
	parameter int TRIG_TIMEOUT = tdi_pkg::TRIG_TIMEOUT_CYC
) (
	input wire logic sys_clk, // System clock, 25 MHz
	input wire logic reset_n, // Synchronous reset, active low (power-up)
	tdi_link_if.camera link, // Link to trigger source / frame grabber
	output logic [6:0] tdi_depth, // Active TDI depth in stages
	output logic slave_mode, // High once in slave operation
	output logic trigger_fault, // High when trigger lost in slave
	output logic [9:0] active_gain [4], // Gain per channel in use
	output logic [9:0] active_offset [4] // Offset per channel in use
);
	// ==========================================
	// Input synchronisers
	logic trig_s;
	logic frame_n_s;
	logic sel_lo_s;
	logic sel_hi_s;
	sync2 u_sync_trig (.sys_clk(sys_clk), .reset_n(reset_n), .d(link.line_trigger_in),
		.q(trig_s));
	// Idle-high pins reset high so no false framing or depth follows reset
	sync2 #(.RST_VAL(1'b1)) u_sync_frame (.sys_clk(sys_clk), .reset_n(reset_n),
		.d(link.frame_select_n), .q(frame_n_s));
	sync2 #(.RST_VAL(1'b1)) u_sync_lo (.sys_clk(sys_clk), .reset_n(reset_n),
		.d(link.depth_select_lo), .q(sel_lo_s));
	sync2 #(.RST_VAL(1'b1)) u_sync_hi (.sys_clk(sys_clk), .reset_n(reset_n),
		.d(link.depth_select_hi), .q(sel_hi_s));

	// ==========================================
	// Operating mode and line start
	tdi_pkg::op_mode_t mode_r, mode_nxt;
	logic trig_d_r, trig_d_nxt;
	logic [15:0] rate_cnt_r, rate_cnt_nxt;
	logic [19:0] idle_cnt_r, idle_cnt_nxt;
	logic fault_r, fault_nxt;
	logic line_start;
	logic trig_rise;
	assign trig_rise = trig_s && !trig_d_r;
	always_comb begin
		mode_nxt = mode_r;
		trig_d_nxt = trig_s;
		rate_cnt_nxt = rate_cnt_r;
		idle_cnt_nxt = idle_cnt_r;
		fault_nxt = fault_r;
		line_start = 1'b0;
		case (mode_r)
			tdi_pkg::ST_MASTER: begin
				// Internal line timing until the first trigger
				if (rate_cnt_r == 16'(tdi_pkg::MASTER_PERIOD_CYC - 1)) begin
					rate_cnt_nxt = 16'h0000;
					line_start = 1'b1;
				end else begin
					rate_cnt_nxt = rate_cnt_r + 16'h0001;
				end
				if (trig_rise) begin
					mode_nxt = tdi_pkg::ST_SLAVE;
					line_start = 1'b1;
					idle_cnt_nxt = 20'h00000;
				end
			end
			tdi_pkg::ST_SLAVE: begin
				// Never returns to master until reset
				if (trig_rise) begin
					line_start = 1'b1;
					idle_cnt_nxt = 20'h00000;
					fault_nxt = 1'b0;
				end else if (idle_cnt_r >= 20'(TRIG_TIMEOUT - 1)) begin
					fault_nxt = 1'b1;
				end else begin
					idle_cnt_nxt = idle_cnt_r + 20'h00001;
				end
			end
			default: mode_nxt = tdi_pkg::ST_MASTER;
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			mode_r <= tdi_pkg::ST_MASTER;
			trig_d_r <= 1'b0;
			rate_cnt_r <= 16'h0000;
			idle_cnt_r <= 20'h00000;
			fault_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			trig_d_r <= trig_d_nxt;
			rate_cnt_r <= rate_cnt_nxt;
			idle_cnt_r <= idle_cnt_nxt;
			fault_r <= fault_nxt;
		end
	end

	// ==========================================
	// Line readout
	tdi_pkg::line_state_t ln_r, ln_nxt;
	logic [9:0] pix_r, pix_nxt;
	logic line_valid_out_nxt;
	logic frame_valid_out_nxt;
	logic [31:0] data_nxt;
	logic framing;
	logic [9:0] gain_r [4];
	logic [9:0] offs_r [4];
	assign framing = (mode_r == tdi_pkg::ST_MASTER) && !frame_n_s;
	always_comb begin
		ln_nxt = ln_r;
		pix_nxt = pix_r;
		line_valid_out_nxt = 1'b0;
		data_nxt = 32'h00000000;
		frame_valid_out_nxt = framing;
		case (ln_r)
			tdi_pkg::LN_IDLE: begin
				// Data only follows a line start, so in slave a stuck trigger gives none
				if (line_start) begin
					ln_nxt = tdi_pkg::LN_OUT;
					pix_nxt = 10'h000;
				end
			end
			tdi_pkg::LN_OUT: begin
				line_valid_out_nxt = 1'b1;
				for (int c = 0; c < tdi_pkg::CHANNELS; c++) begin
					data_nxt[c*8 +: 8] = 8'(pix_r) + 8'(gain_r[c][9:2]) + 8'(offs_r[c][7:0]);
				end
				if (pix_r == 10'(tdi_pkg::LINE_PIXELS - 1)) begin
					ln_nxt = tdi_pkg::LN_IDLE;
				end else begin
					pix_nxt = pix_r + 10'h001;
				end
			end
			default: ln_nxt = tdi_pkg::LN_IDLE;
		endcase
	end

	// ==========================================
	// Gain and offset: working copy and stored copy
	// Stored copy is never reset; its power-up contents are the defaults
	logic [9:0] gain_nv_r [4] = '{default: tdi_pkg::GAIN_RST};
	logic [9:0] offs_nv_r [4] = '{default: tdi_pkg::OFFS_RST};
	logic [9:0] gain_nxt [4];
	logic [9:0] offs_nxt [4];
	logic [9:0] gain_nv_nxt [4];
	logic [9:0] offs_nv_nxt [4];
	always_comb begin
		gain_nxt = gain_r;
		offs_nxt = offs_r;
		gain_nv_nxt = gain_nv_r;
		offs_nv_nxt = offs_nv_r;
		if (link.cal_we) begin
			if (link.cal_addr[2]) offs_nxt[link.cal_addr[1:0]] = link.cal_data;
			else gain_nxt[link.cal_addr[1:0]] = link.cal_data;
		end
		if (link.cal_store) begin
			gain_nv_nxt = gain_r;
			offs_nv_nxt = offs_r;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			// Stored copy survives reset and becomes active
			gain_r <= gain_nv_r;
			offs_r <= offs_nv_r;
		end else begin
			gain_r <= gain_nxt;
			offs_r <= offs_nxt;
			gain_nv_r <= gain_nv_nxt;
			offs_nv_r <= offs_nv_nxt;
		end
	end

	// ==========================================
	// Depth decode and output registers
	logic [6:0] depth_nxt;
	always_comb begin
		case ({sel_hi_s, sel_lo_s})
			2'b11: depth_nxt = 7'h60;
			2'b10: depth_nxt = 7'h40;
			2'b01: depth_nxt = SMALL_ARRAY ? 7'h30 : 7'h20;
			default: depth_nxt = SMALL_ARRAY ? 7'h20 : 7'h10;
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ln_r <= tdi_pkg::LN_IDLE;
			pix_r <= 10'h000;
			link.line_valid_out <= 1'b0;
			link.line_valid_second_out <= 1'b0;
			link.frame_valid_out <= 1'b0;
			link.pixel_data <= 32'h00000000;
			tdi_depth <= tdi_pkg::DEPTH_RST;
			slave_mode <= 1'b0;
			trigger_fault <= 1'b0;
		end else begin
			ln_r <= ln_nxt;
			pix_r <= pix_nxt;
			link.line_valid_out <= line_valid_out_nxt;
			link.line_valid_second_out <= line_valid_out_nxt;
			link.frame_valid_out <= frame_valid_out_nxt;
			link.pixel_data <= data_nxt;
			tdi_depth <= depth_nxt;
			slave_mode <= (mode_nxt == tdi_pkg::ST_SLAVE);
			trigger_fault <= fault_nxt;
		end
	end
	assign active_gain = gain_r;
	assign active_offset = offs_r;
endmodule

// [design/tdi_trigger_source.sv]
// Trigger source end: register port, line trigger generator, frame/depth pins.
// Assumes camera outputs are asynchronous and pass synchronisers here.
module tdi_trigger_source (
	input wire logic sys_clk, // System clock, 25 MHz
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic [3:0] addr, // Register address
	input wire logic [31:0] wdata, // Write data
	input wire logic wr, // Write strobe
	input wire logic rd, // Read strobe
	output logic [31:0] rdata, // Read data, cycle after rd
	tdi_link_if.source link // Link to camera
);
	// ==========================================
	// Registers
	logic [31:0] ctrl_r, ctrl_nxt;
	logic [31:0] rdata_nxt;
	logic [15:0] lines_r, lines_nxt;
	logic [23:0] per_cnt_r, per_cnt_nxt;
	logic trig_r, trig_nxt;
	logic [2:0] hi_cnt_r, hi_cnt_nxt;
	logic we_r, we_nxt, st_r, st_nxt;
	logic [2:0] ca_r, ca_nxt;
	logic [9:0] cd_r, cd_nxt;
	logic line_valid_out_s, line_valid_out_d_r, frame_valid_out_s;
	sync2 u_sync_lv (.sys_clk(sys_clk), .reset_n(reset_n), .d(link.line_valid_out), .q(line_valid_out_s));
	sync2 u_sync_fv (.sys_clk(sys_clk), .reset_n(reset_n), .d(link.frame_valid_out), .q(frame_valid_out_s));
	always_comb begin
		ctrl_nxt = ctrl_r;
		we_nxt = 1'b0;
		st_nxt = 1'b0;
		ca_nxt = ca_r;
		cd_nxt = cd_r;
		if (wr) begin
			if (addr == tdi_pkg::REG_CTRL) begin
				ctrl_nxt = wdata;
				st_nxt = wdata[tdi_pkg::CTRL_STORE];
			end else if (addr[3:2] == 2'b01 || addr[3:2] == 2'b10) begin
				we_nxt = 1'b1;
				ca_nxt = {addr[3], addr[1:0]};
				cd_nxt = wdata[9:0];
			end
		end
		ctrl_nxt[tdi_pkg::CTRL_STORE] = 1'b0;
		lines_nxt = lines_r + 16'((line_valid_out_s && !line_valid_out_d_r) ? 1 : 0);
		case (addr)
			tdi_pkg::REG_CTRL: rdata_nxt = ctrl_r;
			tdi_pkg::REG_STATUS: rdata_nxt = {30'h0, frame_valid_out_s, line_valid_out_s};
			tdi_pkg::REG_LINES: rdata_nxt = {16'h0000, lines_r};
			default: rdata_nxt = 32'h00000000;
		endcase
		if (!rd) rdata_nxt = 32'h00000000;
		// Trigger generator; period in cycles from control register
		trig_nxt = trig_r;
		per_cnt_nxt = per_cnt_r + 24'h000001;
		hi_cnt_nxt = hi_cnt_r;
		if (!ctrl_r[tdi_pkg::CTRL_TRIG_EN]) begin
			trig_nxt = 1'b0;
			per_cnt_nxt = 24'h000000;
		end else if (trig_r) begin
			// Keep high for the minimum time before falling
			if (hi_cnt_r == 3'(tdi_pkg::TRIG_HIGH_CYC)) begin
				trig_nxt = 1'b0;
			end else begin
				hi_cnt_nxt = hi_cnt_r + 3'h1;
			end
		end else if (per_cnt_r >= ctrl_r[31:tdi_pkg::CTRL_RATE_LSB]) begin
			trig_nxt = 1'b1;
			hi_cnt_nxt = 3'h0;
			per_cnt_nxt = 24'h000000;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ctrl_r <= tdi_pkg::CTRL_RST;
			rdata <= 32'h00000000;
			lines_r <= 16'h0000;
			per_cnt_r <= 24'h000000;
			trig_r <= 1'b0;
			hi_cnt_r <= 3'h0;
			we_r <= 1'b0;
			st_r <= 1'b0;
			ca_r <= 3'h0;
			cd_r <= 10'h000;
			line_valid_out_d_r <= 1'b0;
			link.line_trigger_in <= 1'b0;
			link.frame_select_n <= 1'b1;
			link.depth_select_lo <= 1'b1;
			link.depth_select_hi <= 1'b1;
		end else begin
			ctrl_r <= ctrl_nxt;
			rdata <= rdata_nxt;
			lines_r <= lines_nxt;
			per_cnt_r <= per_cnt_nxt;
			trig_r <= trig_nxt;
			hi_cnt_r <= hi_cnt_nxt;
			we_r <= we_nxt;
			st_r <= st_nxt;
			ca_r <= ca_nxt;
			cd_r <= cd_nxt;
			line_valid_out_d_r <= line_valid_out_s;
			link.line_trigger_in <= trig_nxt;
			link.frame_select_n <= !ctrl_nxt[tdi_pkg::CTRL_FRAME];
			link.depth_select_lo <= ctrl_nxt[tdi_pkg::CTRL_SEL_LO];
			link.depth_select_hi <= ctrl_nxt[tdi_pkg::CTRL_SEL_HI];
		end
	end
	assign link.cal_we = we_r;
	assign link.cal_store = st_r;
	assign link.cal_addr = ca_r;
	assign link.cal_data = cd_r;
endmodule

// [verification/tdi_link_asserts.sv]
// Assertions on the camera link signals.
// Assumes one sys_clk domain and a synchronous active-low reset.
module tdi_link_asserts (
	input wire logic sys_clk, // Clock
	input wire logic reset_n, // Sync reset, active low
	input wire logic line_trigger_in, // Trigger
	input wire logic frame_select_n, // Framing request, low
	input wire logic depth_select_lo, // Depth select bit 0
	input wire logic depth_select_hi, // Depth select bit 1
	input wire logic line_valid_out, // Line valid
	input wire logic line_valid_second_out, // Line valid copy
	input wire logic frame_valid_out // Framing active
);
	logic [10:0] run_r, run_nxt, gap_r, gap_nxt;
	logic [3:0] since_r, since_nxt;
	logic prev_r, prev_nxt, trig_r, trig_nxt, seen_r, seen_nxt, rise, edge_t;
	// ====
	// Line length, line spacing and trigger history
	always_comb begin
		rise = line_valid_out && run_r == 11'h000;
		edge_t = line_trigger_in && !trig_r;
		run_nxt = line_valid_out ? run_r + 11'h001 : 11'h000;
		gap_nxt = rise ? 11'h001 : gap_r + {10'h000, gap_r != 11'h7FF};
		since_nxt = edge_t ? 4'h0 : since_r + {3'h0, since_r != 4'hF};
		prev_nxt = prev_r | rise;
		trig_nxt = line_trigger_in;
		seen_nxt = seen_r | edge_t;
	end
	always_ff @(posedge sys_clk) begin
		{run_r, gap_r, since_r, prev_r, trig_r, seen_r} <= reset_n ?
			{run_nxt, gap_nxt, since_nxt, prev_nxt, trig_nxt, seen_nxt} : '0;
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	// ====
	// Properties
	property p_start;
		$rose(line_trigger_in) && !line_valid_out |-> ##[2:6] line_valid_out;
	endproperty
	a_start: assert property (p_start) else $error("trigger started no line");
	property p_len;
		$fell(line_valid_out) |-> run_r == 11'(tdi_pkg::LINE_PIXELS);
	endproperty
	a_len: assert property (p_len) else $error("line length wrong");
	property p_pair;
		line_valid_second_out == line_valid_out;
	endproperty
	a_pair: assert property (p_pair) else $error("line valid copies differ");
	property p_cause;
		$rose(line_valid_out) && seen_r |-> since_r <= 4'h6;
	endproperty
	a_cause: assert property (p_cause) else $error("slave line without trigger");
	property p_master;
		$rose(line_valid_out) && prev_r && !seen_r |-> gap_r == 11'(tdi_pkg::MASTER_PERIOD_CYC);
	endproperty
	a_master: assert property (p_master) else $error("master period wrong");
	property p_frame;
		$rose(frame_valid_out) |-> !frame_select_n && !seen_r;
	endproperty
	a_frame: assert property (p_frame) else $error("framing without request");
	property p_high;
		$rose(line_trigger_in) |-> line_trigger_in [*3];
	endproperty
	a_high: assert property (p_high) else $error("trigger pulse too short");
	property p_idle;
		$rose(reset_n) |-> !line_trigger_in && frame_select_n && depth_select_lo && depth_select_hi;
	endproperty
	a_idle: assert property (p_idle) else $error("link not idle after reset");
endmodule

// [verification/tdi_line_trigger_control_tb.sv]
// Testbench: trigger source and camera joined over one link.
// Assumes the design files are compiled first; a second pair runs the small array.
module tdi_line_trigger_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic [6:0] depth, depth_s;
	logic slave, fault;
	logic [9:0] gain [4];
	logic [9:0] offs [4];
	int error_cnt = 0;
	int tests_run = 0;
	int n;
	tdi_link_if link ();
	tdi_link_if link_s ();
	always #20 sys_clk = ~sys_clk;
	tdi_trigger_source u_tdi_trigger_source (.sys_clk(sys_clk), .reset_n(reset_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link));
	tdi_trigger_source u_tdi_trigger_source_s (.sys_clk(sys_clk), .reset_n(reset_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(), .link(link_s));
	tdi_camera_ctrl #(.TRIG_TIMEOUT(2000)) u_tdi_camera_ctrl (.sys_clk(sys_clk),
		.reset_n(reset_n), .link(link), .tdi_depth(depth), .slave_mode(slave),
		.trigger_fault(fault), .active_gain(gain), .active_offset(offs));
	tdi_camera_ctrl #(.SMALL_ARRAY(1'b1), .TRIG_TIMEOUT(2000)) u_tdi_camera_ctrl_s (
		.sys_clk(sys_clk), .reset_n(reset_n), .link(link_s), .tdi_depth(depth_s),
		.slave_mode(), .trigger_fault(), .active_gain(), .active_offset());
	tdi_link_asserts u_tdi_link_asserts (.sys_clk(sys_clk), .reset_n(reset_n),
		.line_trigger_in(link.line_trigger_in), .frame_select_n(link.frame_select_n),
		.depth_select_lo(link.depth_select_lo), .depth_select_hi(link.depth_select_hi),
		.line_valid_out(link.line_valid_out),
		.line_valid_second_out(link.line_valid_second_out),
		.frame_valid_out(link.frame_valid_out));
	// ====
	// Shared tasks
	task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", s, exp, seen);
		end
	endtask
	task wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task rreg(input logic [3:0] a);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task wt(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	// Counts cycles in n until line valid reaches lvl, bounded
	task wl(input logic lvl);
		#1;
		while (link.line_valid_out !== lvl && n < 4000) begin
			wt(1);
			n++;
		end
		// A line edge that never comes counts as a mismatch
		if (link.line_valid_out !== lvl) error_cnt++;
	endtask
	task do_reset;
		@(posedge sys_clk);
		reset_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		wt(2);
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ====
	// Scenarios
	task t_reset;
		chk("depth", depth, 32'h60);
		chk("slave", slave, 0);
		for (int i = 0; i < 4; i++) begin
			chk("gain", gain[i], tdi_pkg::GAIN_RST);
			chk("offset", offs[i], tdi_pkg::OFFS_RST);
		end
		rreg(4'h3);
		chk("unmapped read", v, 32'h0);
	endtask
	task t_depth;
		logic [6:0] big [4];
		logic [6:0] sml [4];
		big = '{7'h10, 7'h20, 7'h40, 7'h60};
		sml = '{7'h20, 7'h30, 7'h40, 7'h60};
		for (int c = 0; c < 4; c++) begin
			wreg(tdi_pkg::REG_CTRL, 32'(c) << tdi_pkg::CTRL_SEL_LO);
			wt(8);
			chk("select pins", {30'h0, link.depth_select_hi, link.depth_select_lo}, c);
			chk("depth", depth, big[c]);
			chk("small depth", depth_s, sml[c]);
			rreg(tdi_pkg::REG_CTRL);
			chk("control readback", v, 32'(c) << tdi_pkg::CTRL_SEL_LO);
		end
	endtask
	task t_frame;
		wreg(tdi_pkg::REG_CTRL, 32'h0000000E);
		n = 0;
		wl(1'b0);
		wl(1'b1);
		n = 0;
		wl(1'b0);
		wl(1'b1);
		chk("master period", n, tdi_pkg::MASTER_PERIOD_CYC);
		chk("frame select", link.frame_select_n, 0);
		chk("frame valid", link.frame_valid_out, 1);
		wreg(tdi_pkg::REG_CTRL, 32'h0000000C);
	endtask
	task t_cal;
		wreg(tdi_pkg::REG_GAIN0 + 4'h2, 32'h000002A5);
		wreg(tdi_pkg::REG_OFFS0 + 4'h1, 32'h00000011);
		wt(6);
		for (int i = 0; i < 4; i++) begin
			chk("gain", gain[i], i == 2 ? 10'h2A5 : tdi_pkg::GAIN_RST);
			chk("offset", offs[i], i == 1 ? 10'h011 : tdi_pkg::OFFS_RST);
		end
	endtask
	task t_store;
		wreg(tdi_pkg::REG_CTRL, 32'h0000001C);
		wreg(tdi_pkg::REG_GAIN0 + 4'h2, 32'h00000111);
		wt(6);
		chk("gain after store", gain[2], 10'h111);
		do_reset();
		chk("gain reloaded", gain[2], 10'h2A5);
		chk("offset reloaded", offs[1], 10'h011);
	endtask
	task t_trig;
		wreg(tdi_pkg::REG_CTRL, 32'h0005DC0D);
		// First trigger comes one full period after enable
		wt(1600);
		chk("slave", slave, 1);
		n = 0;
		wl(1'b0);
		wl(1'b1);
		n = 0;
		wl(1'b0);
		chk("line length", n, tdi_pkg::LINE_PIXELS);
		wl(1'b1);
		// Source counts from zero up to the period value, one cycle more
		chk("slave period", n, 32'h5DD);
	endtask
	task t_fault;
		int m;
		m = 0;
		// Trigger off and framing requested while in slave
		wreg(tdi_pkg::REG_CTRL, 32'h0000000E);
		wt(600);
		chk("framing in slave", link.frame_valid_out, 0);
		repeat (1500) begin
			wt(1);
			m += int'(link.line_valid_out === 1'b1);
		end
		chk("idle lines", m, 0);
		chk("fault", fault, 1);
		chk("still slave", slave, 1);
		wreg(tdi_pkg::REG_CTRL, 32'h0005DC0D);
		n = 0;
		wl(1'b1);
		wt(2);
		chk("fault cleared", fault, 0);
	endtask
	initial begin
		#2400000;
		error_cnt++;
		give_verdict();
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		wt(2);
		t_reset();
		t_depth();
		t_frame();
		t_cal();
		t_store();
		t_trig();
		t_fault();
		do_reset();
		chk("master after reset", slave, 0);
		give_verdict();
	end
endmodule
